// [bench/display_ram_setup_command_decoder_tb.sv]
// display_ram_setup_command_decoder_tb: host end driving the decoder.
// assumes the user side of the host end is the only stimulus point.
`timescale 1ns/1ps
module display_ram_setup_command_decoder_tb;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic wide_i = 1'b0;
  logic req_i = 1'b0;
  logic is_param_i = 1'b0;
  logic is_read_i = 1'b0;
  logic [15:0] data_i = 16'h0000;
  logic ack_o, rvalid_o, vinc, colrev, swap, comrev, split;
  logic [15:0] rdata_o;
  logic [1:0] depth;
  logic [6:0] cs, ce, rs, re;
  int miscompares = 0;
  int cmp_count = 0;
  integer seed = 32'h61b26177;
  logic [15:0] exp_q[$];
  logic [15:0] mem[8];
  int i, w;
  logic [7:0] v, prev;
  wire [15:0] remap_w = {8'h00, depth, split, comrev, 1'b0, swap, colrev,
    vinc};
  wire [15:0] col_w = {1'b0, cs, 1'b0, ce};
  wire [15:0] row_w = {1'b0, rs, 1'b0, re};

  initial begin
    forever #50 clk_i = ~clk_i;
  end

  drsc_link_if link();
  drsc_host u_drsc_host (.clk_i(clk_i), .resetn_i(resetn_i), .link(link),
    .wide_i(wide_i), .req_i(req_i), .is_param_i(is_param_i),
    .is_read_i(is_read_i), .data_i(data_i), .ack_o(ack_o),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o));
  drsc_device u_drsc_device (.clk_i(clk_i), .resetn_i(resetn_i),
    .link(link), .vert_inc_o(vinc), .col_remap_o(colrev),
    .color_swap_o(swap), .com_reverse_o(comrev), .com_split_o(split),
    .color_depth_o(depth), .col_start_o(cs), .col_end_o(ce),
    .row_start_o(rs), .row_end_o(re));
  drsc_link_sva u_drsc_link_sva (.clk_i(clk_i), .resetn_i(resetn_i),
    .wr_strobe_i(link.wr_strobe), .rd_strobe_i(link.rd_strobe),
    .wide_bus_i(link.wide_bus), .rdata_i(link.rdata),
    .rvalid_i(link.rvalid), .wready_i(link.wready));

  task automatic check(input string name, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // request held until ack is seen, released at the taking edge
  task automatic send(input logic p, r, input logic [15:0] d);
    int n;
    @(posedge clk_i);
    req_i <= 1'b1;
    is_param_i <= p;
    is_read_i <= r;
    data_i <= d;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 200);
    @(posedge clk_i);
    req_i <= 1'b0;
  endtask

  // settings land one cycle after the last parameter strobe
  task automatic cmd3(input logic [7:0] op, a, b);
    send(1'b0, 1'b0, {8'h00, op});
    send(1'b1, 1'b0, {8'h00, a});
    send(1'b1, 1'b0, {8'h00, b});
    repeat (2) @(posedge clk_i);
  endtask

  always @(posedge clk_i) begin
    if (rvalid_o === 1'b1) begin
      if (exp_q.size() == 0)
        check("extra_read", 16'(exp_q.size()), 16'h0001);
      else
        check("rdata", rdata_o, exp_q.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    $display("mismatch watchdog expected done seen hang");
    end_sim();
  end

  initial begin
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    check("remap", remap_w, 16'h0060);
    check("col_win", col_w, 16'h007f);
    check("row_win", row_w, 16'h007f);
    $display("test reset defaults done");
    for (w = 0; w < 2; w++) begin
      wide_i <= w[0];
      cmd3(8'h15, 8'h82, 8'h85);
      check("col_win", col_w, 16'h0205);
      cmd3(8'h75, 8'h01, 8'h02);
      check("row_win", row_w, 16'h0102);
      send(1'b0, 1'b0, 16'h005c);
      for (i = 0; i < 8; i++) begin
        mem[i] = 16'($random(seed));
        send(1'b1, 1'b0, mem[i]);
      end
      // 8 pixels fill the 4x2 window, so the pointer is back at its start
      send(1'b0, 1'b0, 16'h005d);
      repeat (8) @(posedge clk_i);
      for (i = 0; i < 8; i++) begin
        exp_q.push_back(w ? mem[i] : {8'h00, mem[i][7:0]});
        send(1'b1, 1'b1, 16'h0000);
      end
      repeat (4) @(posedge clk_i);
      check("reads_left", 16'(exp_q.size()), 16'h0000);
      $display("test ram window pass %0d done", w);
    end
    // unknown opcode: its parameter bytes must leave every setting alone
    send(1'b0, 1'b0, 16'h00ff);
    send(1'b1, 1'b0, 16'h0033);
    send(1'b1, 1'b0, 16'h0044);
    repeat (2) @(posedge clk_i);
    check("col_win", col_w, 16'h0205);
    check("remap", remap_w, 16'h0060);
    $display("test unknown opcode done");
    prev = 8'h60;
    for (i = 0; i < 4; i++) begin
      v = {2'(i), 6'($random(seed))} & 8'hf7;
      send(1'b0, 1'b0, 16'h00a0);
      send(1'b1, 1'b0, {8'h00, v});
      repeat (2) @(posedge clk_i);
      check("remap_early", remap_w, {8'h00, prev});
      send(1'b1, 1'b0, 16'h0000);
      repeat (2) @(posedge clk_i);
      check("remap", remap_w, {8'h00, v});
      prev = v;
    end
    $display("test remap and depth done");
    // vertical increment fills column by column; read back row by row
    cmd3(8'ha0, 8'h61, 8'h00);
    check("remap", remap_w, 16'h0061);
    cmd3(8'h15, 8'h02, 8'h05);
    cmd3(8'h75, 8'h01, 8'h02);
    send(1'b0, 1'b0, 16'h005c);
    for (i = 0; i < 8; i++) begin
      mem[i] = 16'($random(seed));
      send(1'b1, 1'b0, mem[i]);
    end
    cmd3(8'ha0, 8'h60, 8'h00);
    cmd3(8'h15, 8'h02, 8'h05);
    cmd3(8'h75, 8'h01, 8'h02);
    send(1'b0, 1'b0, 16'h005d);
    repeat (8) @(posedge clk_i);
    for (i = 0; i < 8; i++) begin
      exp_q.push_back(mem[(i % 4) * 2 + i / 4]);
      send(1'b1, 1'b1, 16'h0000);
    end
    repeat (4) @(posedge clk_i);
    check("reads_left", 16'(exp_q.size()), 16'h0000);
    $display("test vertical increment done");
    end_sim();
  end
endmodule

// [bench/drsc_link_sva.sv]
// drsc_link_sva: protocol checks on the link between host and device ends.
// assumes one clock domain; the bench wires it to the link signals.
`timescale 1ns/1ps
module drsc_link_sva (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic wr_strobe_i,
  input wire logic rd_strobe_i,
  input wire logic wide_bus_i,
  input wire logic [15:0] rdata_i,
  input wire logic rvalid_i,
  input wire logic wready_i
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  strobe_width_a: assert property (wr_strobe_i |=> !wr_strobe_i)
    else $error("write strobe wider than one cycle");
  read_width_a: assert property (rd_strobe_i |=> !rd_strobe_i)
    else $error("read strobe wider than one cycle");
  strobe_excl_a: assert property (!(wr_strobe_i && rd_strobe_i))
    else $error("read and write strobes together");
  write_gap_a: assert property (wr_strobe_i |=> !rd_strobe_i)
    else $error("read strobe right after a write");
  read_answer_a: assert property (rvalid_i |-> $past(rd_strobe_i))
    else $error("read data without a read strobe");
  valid_pulse_a: assert property (rvalid_i |=> !rvalid_i)
    else $error("read valid wider than one cycle");
  narrow_read_a: assert property (
    rvalid_i && !wide_bus_i |-> rdata_i[15:8] == 8'h00)
    else $error("upper read byte set in narrow mode");
  ready_reset_a: assert property ($rose(resetn_i) |-> wready_i)
    else $error("data queue not ready after reset");

  cover property (rd_strobe_i ##1 rvalid_i);
  cover property (wr_strobe_i && wide_bus_i);
  cover property (rvalid_i && !wide_bus_i);
endmodule

// [rtl/drsc_device.sv]
// drsc_device: command decoder and graphic ram for the display controller.
// assumes the host keeps its strobes one cycle wide and in clk_i's domain.
`timescale 1ns/1ps
module drsc_device (
  input wire logic clk_i,
  input wire logic resetn_i,
  drsc_link_if.device link,
  output logic vert_inc_o,
  output logic col_remap_o,
  output logic color_swap_o,
  output logic com_reverse_o,
  output logic com_split_o,
  output logic [1:0] color_depth_o,
  output logic [6:0] col_start_o,
  output logic [6:0] col_end_o,
  output logic [6:0] row_start_o,
  output logic [6:0] row_end_o
);
  typedef enum logic [4:0] {
    DRSC_IDLE = 5'b00001,
    DRSC_COLW = 5'b00010,
    DRSC_ROWW = 5'b00100,
    DRSC_REMAP = 5'b01000,
    DRSC_RAM = 5'b10000
  } drsc_state_t;

  typedef struct packed {
    drsc_state_t state;
    logic [1:0] pcnt;
    logic [7:0] first;
    logic ram_rd;
    logic [6:0] col_start;
    logic [6:0] col_end;
    logic [6:0] row_start;
    logic [6:0] row_end;
    logic [6:0] col_ptr;
    logic [6:0] row_ptr;
    logic [7:0] remap;
    logic [15:0] rdata;
    logic rvalid;
  } drsc_dev_st_t;

  drsc_dev_st_t st_reg, st_next;
  logic [15:0] ram [drsc_pkg::RAM_WORDS];
  logic [15:0] fifo_data, wbus;
  logic fifo_valid, fifo_ready, ram_we, adv;
  logic [drsc_pkg::RAM_AW-1:0] addr;

  // 8-bit mode keeps only the low lanes of every transfer
  assign wbus = link.wide_bus ? link.wdata : {8'h00, link.wdata[7:0]};

  // ram data is buffered so a burst of pixel writes never stalls the bus
  drsc_fifo #(.WIDTH(drsc_pkg::BUS_W), .DEPTH(drsc_pkg::FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .in_valid_i(link.wr_strobe && link.dc_sel && st_reg.state == DRSC_RAM
                && !st_reg.ram_rd),
    .in_ready_o(fifo_ready),
    .in_data_i(wbus),
    .out_valid_o(fifo_valid),
    .out_ready_i(ram_we),
    .out_data_o(fifo_data)
  );
  assign link.wready = fifo_ready;
  // the write queue drains every cycle it holds data; a read in such a cycle is dropped
  assign ram_we = fifo_valid;
  // row in the high bits: the 128x128 ram is one flat array
  assign addr = {st_reg.row_ptr, st_reg.col_ptr};

  // write port only; the read port sits in the decoder process
  always_ff @(posedge clk_i) begin
    if (ram_we) begin
      ram[addr] <= fifo_data;
    end
  end

  // a pending write moves the pointer first; a read then is dropped
  always_comb begin
    st_next = st_reg;
    st_next.rvalid = 1'b0;
    adv = 1'b0;
    if (ram_we) begin
      adv = 1'b1;
    end else if (link.rd_strobe && st_reg.state == DRSC_RAM
                 && st_reg.ram_rd) begin
      st_next.rdata = ram[addr];
      st_next.rvalid = 1'b1;
      adv = 1'b1;
    end
    if (adv) begin
      if (!st_reg.remap[drsc_pkg::REMAP_VINC_BIT]) begin
        if (st_reg.col_ptr >= st_reg.col_end) begin
          st_next.col_ptr = st_reg.col_start;
          st_next.row_ptr = (st_reg.row_ptr >= st_reg.row_end) ?
                            st_reg.row_start : st_reg.row_ptr + 7'h01;
        end else begin
          st_next.col_ptr = st_reg.col_ptr + 7'h01;
        end
      end else begin
        if (st_reg.row_ptr >= st_reg.row_end) begin
          st_next.row_ptr = st_reg.row_start;
          st_next.col_ptr = (st_reg.col_ptr >= st_reg.col_end) ?
                            st_reg.col_start : st_reg.col_ptr + 7'h01;
        end else begin
          st_next.row_ptr = st_reg.row_ptr + 7'h01;
        end
      end
    end
    if (link.wr_strobe && !link.dc_sel) begin
      st_next.pcnt = 2'h0;
      st_next.ram_rd = 1'b0;
      unique case (wbus[7:0])
        drsc_pkg::OP_COL_WIN: st_next.state = DRSC_COLW;
        drsc_pkg::OP_ROW_WIN: st_next.state = DRSC_ROWW;
        drsc_pkg::OP_REMAP: st_next.state = DRSC_REMAP;
        drsc_pkg::OP_RAM_WR: st_next.state = DRSC_RAM;
        drsc_pkg::OP_RAM_RD: begin
          st_next.state = DRSC_RAM;
          st_next.ram_rd = 1'b1;
        end
        // unknown opcode parks the decoder; its parameters fall away
        default: st_next.state = DRSC_IDLE;
      endcase
    end else if (link.wr_strobe && link.dc_sel) begin
      unique case (st_reg.state)
        DRSC_COLW, DRSC_ROWW, DRSC_REMAP: begin
          st_next.pcnt = st_reg.pcnt + 2'h1;
          if (st_reg.pcnt == 2'h0) begin
            st_next.first = wbus[7:0];
          end else begin
            st_next.state = DRSC_IDLE;
            // top bit of window parameters is don't care
            if (st_reg.state == DRSC_COLW) begin
              st_next.col_start = st_reg.first[6:0];
              st_next.col_end = wbus[6:0];
              st_next.col_ptr = st_reg.first[6:0];
            end else if (st_reg.state == DRSC_ROWW) begin
              st_next.row_start = st_reg.first[6:0];
              st_next.row_end = wbus[6:0];
              st_next.row_ptr = st_reg.first[6:0];
            end else begin
              // second byte must be zero; its value is not checked
              st_next.remap = st_reg.first;
            end
          end
        end
        DRSC_IDLE, DRSC_RAM: begin
        end
        default: st_next.state = DRSC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_reg <= '{state: DRSC_IDLE,
                  pcnt: 2'h0,
                  first: 8'h00,
                  ram_rd: 1'b0,
                  col_start: drsc_pkg::COL_START_RST,
                  col_end: drsc_pkg::COL_END_RST,
                  row_start: drsc_pkg::ROW_START_RST,
                  row_end: drsc_pkg::ROW_END_RST,
                  col_ptr: drsc_pkg::COL_START_RST,
                  row_ptr: drsc_pkg::ROW_START_RST,
                  remap: drsc_pkg::REMAP_RST,
                  rdata: 16'h0000,
                  rvalid: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign link.rdata = link.wide_bus ? st_reg.rdata :
                      {8'h00, st_reg.rdata[7:0]};
  assign link.rvalid = st_reg.rvalid;
  assign vert_inc_o = st_reg.remap[drsc_pkg::REMAP_VINC_BIT];
  assign col_remap_o = st_reg.remap[drsc_pkg::REMAP_COLREV_BIT];
  assign color_swap_o = st_reg.remap[drsc_pkg::REMAP_SWAP_BIT];
  // reserved bit is stored but drives nothing;
  // a host that sets it sees no effect on the panel side
  assign com_reverse_o = st_reg.remap[drsc_pkg::REMAP_COMREV_BIT];
  assign com_split_o = st_reg.remap[drsc_pkg::REMAP_SPLIT_BIT];
  assign color_depth_o =
    st_reg.remap[drsc_pkg::REMAP_DEPTH_LSB +: 2];
  assign col_start_o = st_reg.col_start;
  assign col_end_o = st_reg.col_end;
  assign row_start_o = st_reg.row_start;
  assign row_end_o = st_reg.row_end;
endmodule

// [rtl/drsc_fifo.sv]
// drsc_fifo: synchronous valid/ready fifo, parameter width and depth.
// assumes one clock; depth is a power of two.
`timescale 1ns/1ps
module drsc_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } drsc_fifo_st_t;
  drsc_fifo_st_t st_reg, st_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic full, empty, push, pop;

  assign empty = st_reg.wp == st_reg.rp;
  assign full = (st_reg.wp[AW-1:0] == st_reg.rp[AW-1:0]) &&
                (st_reg.wp[AW] != st_reg.rp[AW]);
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign push = in_valid_i && !full;
  assign pop = out_ready_i && !empty;
  assign out_data_o = mem[st_reg.rp[AW-1:0]];

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.wp = st_reg.wp + 1'b1;
    end
    if (pop) begin
      st_next.rp = st_reg.rp + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[st_reg.wp[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

// [rtl/drsc_host.sv]
// drsc_host: host end; turns user requests into opcode/parameter strobes.
// assumes the user holds a request until ack_o pulses.
`timescale 1ns/1ps
module drsc_host (
  input wire logic clk_i,
  input wire logic resetn_i,
  drsc_link_if.host link,
  input wire logic wide_i,
  input wire logic req_i,
  input wire logic is_param_i,
  input wire logic is_read_i,
  input wire logic [15:0] data_i,
  output logic ack_o,
  output logic [15:0] rdata_o,
  output logic rvalid_o
);
  typedef struct packed {
    logic wr;
    logic rd;
    logic dc;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic rvalid;
  } drsc_host_st_t;
  drsc_host_st_t st_reg, st_next;
  logic fire;

  // one strobe per request; a write waits for room in the device queue
  assign fire = req_i && !st_reg.wr && !st_reg.rd &&
                (is_read_i || link.wready);
  assign ack_o = fire;

  always_comb begin
    st_next = st_reg;
    st_next.wr = fire && !is_read_i;
    st_next.rd = fire && is_read_i;
    st_next.rvalid = link.rvalid;
    if (fire) begin
      st_next.dc = is_read_i | is_param_i;
      st_next.wdata = wide_i ? data_i : {8'h00, data_i[7:0]};
    end
    if (link.rvalid) begin
      st_next.rdata = link.rdata;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign link.wr_strobe = st_reg.wr;
  assign link.rd_strobe = st_reg.rd;
  assign link.dc_sel = st_reg.dc;
  assign link.wdata = st_reg.wdata;
  assign link.wide_bus = wide_i;
  assign rdata_o = st_reg.rdata;
  assign rvalid_o = st_reg.rvalid;
endmodule

// [rtl/drsc_link_if.sv]
// drsc_link_if: host bus between controller logic and the decoder.
// assumes both ends share clk; dc low marks an opcode, high a data byte.
`timescale 1ns/1ps
interface drsc_link_if;
  logic wr_strobe;
  logic rd_strobe;
  logic dc_sel;
  logic wide_bus;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic rvalid;
  logic wready;

  modport device (
    input wr_strobe,
    input rd_strobe,
    input dc_sel,
    input wide_bus,
    input wdata,
    output rdata,
    output rvalid,
    output wready
  );
  modport host (
    output wr_strobe,
    output rd_strobe,
    output dc_sel,
    output wide_bus,
    output wdata,
    input rdata,
    input rvalid,
    input wready
  );
endinterface

// [rtl/drsc_pkg.sv]
// drsc_pkg: opcodes, field positions, reset values and widths used by the
// display ram setup decoder, which also sizes the data fifo from them.
// assumes a single 10 MHz clock domain on both ends.
package drsc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned BUS_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned RAM_WORDS = 16384;
  localparam int unsigned RAM_AW = 14;

  localparam logic [7:0] OP_COL_WIN = 8'h15;
  localparam logic [7:0] OP_ROW_WIN = 8'h75;
  localparam logic [7:0] OP_RAM_WR = 8'h5c;
  localparam logic [7:0] OP_RAM_RD = 8'h5d;
  localparam logic [7:0] OP_REMAP = 8'ha0;

  localparam logic [6:0] COL_START_RST = 7'h00;
  localparam logic [6:0] COL_END_RST = 7'h7f;
  localparam logic [6:0] ROW_START_RST = 7'h00;
  localparam logic [6:0] ROW_END_RST = 7'h7f;
  localparam logic [7:0] REMAP_RST = 8'h60;

  localparam int unsigned REMAP_VINC_BIT = 0;
  localparam int unsigned REMAP_COLREV_BIT = 1;
  localparam int unsigned REMAP_SWAP_BIT = 2;
  localparam int unsigned REMAP_RSVD_BIT = 3;
  localparam int unsigned REMAP_COMREV_BIT = 4;
  localparam int unsigned REMAP_SPLIT_BIT = 5;
  localparam int unsigned REMAP_DEPTH_LSB = 6;

  localparam logic [1:0] DEPTH_256 = 2'h0;
  localparam logic [1:0] DEPTH_65K = 2'h1;
  localparam logic [1:0] DEPTH_262K = 2'h2;
  localparam logic [1:0] DEPTH_P262K = 2'h3;

  localparam logic [1:0] PARAM_CNT_TWO = 2'h2;
endpackage
